// *** rtl/lpl_regs.svh ***
// Register offsets, reset values, sizes and table and output indices of the low-bank lookup logic.
`ifndef LPL_REGS_SVH
`define LPL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LPL_ADDR_A_PIN3_SINGLE 8'h27
`define LPL_ADDR_B_PIN11 8'h28
`define LPL_ADDR_A_PIN3_DUAL 8'h29
`define LPL_ADDR_B_PIN12 8'h2A
`define LPL_ADDR_A_PIN4 8'h2B

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define LPL_TABLE_RESET 8'h00
`define LPL_NUM_TABLES 5
`define LPL_NUM_OUTS 4
`define LPL_READ_MISS 8'h00

// ----------------------------------------------------------------------------
// Table and output indices
// ----------------------------------------------------------------------------
`define LPL_T_A_SINGLE 0
`define LPL_T_B_PIN11 1
`define LPL_T_A_DUAL 2
`define LPL_T_B_PIN12 3
`define LPL_T_A_PIN4 4
`define LPL_O_PIN3 0
`define LPL_O_PIN4 1
`define LPL_O_PIN11 2
`define LPL_O_PIN12 3

`endif

// *** rtl/lpl_pkg.sv ***
// Types shared by the low-bank lookup logic.
package lpl_pkg;

    // ------------------------------------------------------------------------
    // Logic mode of one low bank
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        LPL_MODE_OFF = 2'h0,
        LPL_MODE_2TO1 = 2'h1,
        LPL_MODE_3TO1 = 2'h2,
        LPL_MODE_3TO2 = 2'h3
    } lpl_mode_e;

    typedef logic [7:0] lpl_table_t;
    typedef logic [2:0] lpl_sel_t;

endpackage

// *** rtl/lpl_lut_out.sv ***
// One registered lookup output: picks a table bit by a 3-bit input code.
`timescale 1ns/100ps
`include "lpl_regs.svh"

module lpl_lut_out
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Lookup inputs
    input wire logic enable_i,
    input wire lpl_pkg::lpl_table_t table_i,
    input wire lpl_pkg::lpl_sel_t sel_i,
    // Pin drive
    output logic value_o,
    output logic drive_o
);
    import lpl_pkg::*;

    logic value_d;
    logic value_q;
    logic drive_d;
    logic drive_q;

    // ------------------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------------------

    // Bit n of the table answers input code n; a disabled output stays low.
    always_comb
    begin
        drive_d = enable_i;
        value_d = enable_i ? table_i[sel_i] : 1'b0;
    end

    // One register stage keeps the pin glitch free; the cost is one clock of lag.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            value_q <= 1'b0;
            drive_q <= 1'b0;
        end
        else
        begin
            value_q <= value_d;
            drive_q <= drive_d;
        end
    end

    assign value_o = value_q;
    assign drive_o = drive_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_LUT_FOLLOWS: assert property (@(posedge clk_i) disable iff (reset_i)
        enable_i |=> value_o == $past(table_i[sel_i]))
    else $error("Lookup output does not match table bit.");

    AST_LUT_IDLE_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
        !enable_i |=> !value_o && !drive_o)
    else $error("Disabled lookup output is not quiet.");

endmodule

// *** rtl/lpl_top.sv ***
// Low-bank three-input lookup logic: truth-table registers and pin drive.
// Behaviour
// - Bank A 3-to-1: pin 3 from table 0x27.
// - Bank B 3-to-2: pin 11 from table 0x28.
// - Bank A 3-to-2: pin 3 from table 0x29.
// - Bank B 3-to-2: pin 12 from table 0x2A.
// - Table bit n answers input code n.
// - Pins 11, 12 evaluated together, own tables.
// - Tables act only in matching lookup mode.
// - Tables 0x28 to 0x2A reset to zero.
// - Single-output table at 0x27, resets zero.
// - Bank A 3-to-2: pin 4 from 0x2B.
`timescale 1ns/100ps
`include "lpl_regs.svh"

module lpl_top
(
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    // Register access port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // Bank mode fields
    input wire lpl_pkg::lpl_mode_e BANK_A_LOW_LOGIC_MODE_I,
    input wire lpl_pkg::lpl_mode_e BANK_B_LOW_LOGIC_MODE_I,
    // Selecting pins
    input wire lpl_pkg::lpl_sel_t IO_A_LOW_SEL_I,
    input wire lpl_pkg::lpl_sel_t IO_B_LOW_SEL_I,
    // Lookup pin drive
    output logic [3:0] LUT_VALUE_O,
    output logic [3:0] LUT_DRIVE_O
);
    import lpl_pkg::*;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // Maps a register address to a table index; hit is low for unmapped ones.
    function automatic logic [3:0] table_index(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - `LPL_ADDR_A_PIN3_SINGLE;
        if (addr >= `LPL_ADDR_A_PIN3_SINGLE && addr <= `LPL_ADDR_A_PIN4)
            table_index = {1'b1, off[2:0]};
        else
            table_index = 4'h0;
    endfunction

    lpl_table_t table_q [`LPL_NUM_TABLES];
    lpl_table_t table_d [`LPL_NUM_TABLES];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;

    assign wr_idx = table_index(REG_ADDR_I);
    assign rd_idx = table_index(REG_ADDR_I);

    // ------------------------------------------------------------------------
    // Truth-table registers
    // ------------------------------------------------------------------------

    // A write lands in the addressed table; writes elsewhere are dropped.
    always_comb
    begin
        for (int i = 0; i < `LPL_NUM_TABLES; i++)
        begin
            table_d[i] = table_q[i];
            if (REG_WR_I && wr_idx[3] && wr_idx[2:0] == 3'(i))
                table_d[i] = REG_WDATA_I;
        end
        rdata_d = rdata_q;
        if (REG_RD_I)
            rdata_d = rd_idx[3] ? table_q[rd_idx[2:0]] : `LPL_READ_MISS;
    end

    // Every table clears on reset so an enabled output starts low.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            for (int i = 0; i < `LPL_NUM_TABLES; i++)
                table_q[i] <= `LPL_TABLE_RESET;
            rdata_q <= `LPL_READ_MISS;
        end
        else
        begin
            for (int i = 0; i < `LPL_NUM_TABLES; i++)
                table_q[i] <= table_d[i];
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA_O = rdata_q;

    // ------------------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------------------
    logic a_single;
    logic a_dual;
    logic b_dual;
    lpl_table_t out_table [`LPL_NUM_OUTS];
    lpl_sel_t out_sel [`LPL_NUM_OUTS];
    logic [3:0] out_en;

    // Only the lookup modes hand the tables to the pins.
    assign a_single = BANK_A_LOW_LOGIC_MODE_I == LPL_MODE_3TO1;
    assign a_dual = BANK_A_LOW_LOGIC_MODE_I == LPL_MODE_3TO2;
    assign b_dual = BANK_B_LOW_LOGIC_MODE_I == LPL_MODE_3TO2;

    // Pin 3 swaps tables with the mode; pin 11 and 12 share one select code.
    always_comb
    begin
        out_table[`LPL_O_PIN3] = a_dual ? table_q[`LPL_T_A_DUAL] : table_q[`LPL_T_A_SINGLE];
        out_sel[`LPL_O_PIN3] = IO_A_LOW_SEL_I;
        out_en[`LPL_O_PIN3] = a_single | a_dual;
        out_table[`LPL_O_PIN4] = table_q[`LPL_T_A_PIN4];
        out_sel[`LPL_O_PIN4] = IO_A_LOW_SEL_I;
        out_en[`LPL_O_PIN4] = a_dual;
        out_table[`LPL_O_PIN11] = table_q[`LPL_T_B_PIN11];
        out_sel[`LPL_O_PIN11] = IO_B_LOW_SEL_I;
        out_en[`LPL_O_PIN11] = b_dual;
        out_table[`LPL_O_PIN12] = table_q[`LPL_T_B_PIN12];
        out_sel[`LPL_O_PIN12] = IO_B_LOW_SEL_I;
        out_en[`LPL_O_PIN12] = b_dual;
    end

    // All four outputs register on the same edge, so pins 11 and 12 never skew.
    for (genvar g = 0; g < `LPL_NUM_OUTS; g++)
    begin : g_out
        lpl_lut_out u_lut
        (
            .clk_i(CLK_SYS_I),
            .reset_i(RESET_I),
            .enable_i(out_en[g]),
            .table_i(out_table[g]),
            .sel_i(out_sel[g]),
            .value_o(LUT_VALUE_O[g]),
            .drive_o(LUT_DRIVE_O[g])
        );
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Pin checks compare against the table one clock back, matching the output stage.
    AST_PIN3_SINGLE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        a_single |=> LUT_VALUE_O[0] == $past(table_q[0][IO_A_LOW_SEL_I]) && LUT_DRIVE_O[0])
    else $error("Pin 3 wrong in single-output mode.");

    AST_PIN11_DUAL: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        b_dual |=> LUT_VALUE_O[2] == $past(table_q[1][IO_B_LOW_SEL_I]))
    else $error("Pin 11 wrong in dual-output mode.");

    AST_PIN3_DUAL: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        a_dual |=> LUT_VALUE_O[0] == $past(table_q[2][IO_A_LOW_SEL_I]))
    else $error("Pin 3 wrong in dual-output mode.");

    AST_PIN12_DUAL: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        b_dual |=> LUT_VALUE_O[3] == $past(table_q[3][IO_B_LOW_SEL_I]))
    else $error("Pin 12 wrong in dual-output mode.");

    AST_B_TOGETHER: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        b_dual |=> LUT_DRIVE_O[2] && LUT_DRIVE_O[3])
    else $error("Pins 11 and 12 not driven together.");

    AST_OFF_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        !a_single && !a_dual |=> LUT_VALUE_O[1:0] == 2'h0 && LUT_DRIVE_O[1:0] == 2'h0)
    else $error("Bank A pins driven outside lookup modes.");

    AST_RESET_ZERO: assert property (@(posedge CLK_SYS_I)
        RESET_I |=> table_q[1] == 8'h00 && table_q[2] == 8'h00 && table_q[3] == 8'h00)
    else $error("Table not cleared by reset.");

    AST_SINGLE_RESET: assert property (@(posedge CLK_SYS_I)
        RESET_I |=> table_q[0] == 8'h00)
    else $error("Single-output table not cleared by reset.");

    AST_PIN4_DUAL: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        a_dual |=> LUT_VALUE_O[1] == $past(table_q[4][IO_A_LOW_SEL_I]))
    else $error("Pin 4 wrong in dual-output mode.");

    AST_WRITE_SHOWS: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        REG_WR_I && REG_ADDR_I == 8'h29 && a_dual ##1 a_dual && IO_A_LOW_SEL_I == 3'h0
        |=> LUT_VALUE_O[0] == $past(REG_WDATA_I[0], 2))
    else $error("Table write not reflected on pin within one clock.");

    // Outputs that a mode leaves unused must stay released, so no pin is fought over.
    AST_B_OFF_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        !b_dual |=> LUT_VALUE_O[3:2] == 2'h0 && LUT_DRIVE_O[3:2] == 2'h0)
    else $error("Bank B pins driven outside lookup mode.");

    AST_PIN4_SINGLE_OFF: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        a_single |=> !LUT_VALUE_O[1] && !LUT_DRIVE_O[1])
    else $error("Pin 4 driven in single-output mode.");

    AST_A_DUAL_DRIVE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        a_dual |=> LUT_DRIVE_O[1:0] == 2'h3)
    else $error("Pins 3 and 4 not driven in dual-output mode.");

    // A host write must land in its own table on the next edge.
    AST_SINGLE_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        REG_WR_I && REG_ADDR_I == `LPL_ADDR_A_PIN3_SINGLE |=> table_q[`LPL_T_A_SINGLE] == $past(REG_WDATA_I))
    else $error("Write to the single-output table lost.");

    AST_PIN11_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        REG_WR_I && REG_ADDR_I == `LPL_ADDR_B_PIN11 |=> table_q[`LPL_T_B_PIN11] == $past(REG_WDATA_I))
    else $error("Write to the pin 11 table lost.");

    AST_PIN12_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        REG_WR_I && REG_ADDR_I == `LPL_ADDR_B_PIN12 |=> table_q[`LPL_T_B_PIN12] == $past(REG_WDATA_I))
    else $error("Write to the pin 12 table lost.");

    COV_A_SINGLE: cover property (@(posedge CLK_SYS_I) a_single ##1 LUT_VALUE_O[0]);
    COV_A_DUAL: cover property (@(posedge CLK_SYS_I) a_dual ##1 LUT_VALUE_O[1]);
    COV_B_DUAL: cover property (@(posedge CLK_SYS_I) b_dual ##1 LUT_VALUE_O[2] && LUT_VALUE_O[3]);
    COV_READ: cover property (@(posedge CLK_SYS_I) REG_RD_I && REG_ADDR_I == 8'h2A);

endmodule

// *** tb/lpl_host_model.sv ***
// Host model that drives the register port of the lookup block.
`timescale 1ns/100ps

module lpl_host_model
(
    // Clock
    input wire logic clk_i,
    // Register access port
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // Lines start quiet; no strobe is raised before reset is released.
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // One write with the strobe standing for a single rising edge.
    // Idle lines show the inverse of the last value, so a stale sample cannot match by luck.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask

    // One read; the data is taken one and a half cycles after the taking edge.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        @(negedge clk_i);
        data = reg_rdata_i;
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the low-bank lookup logic.
`timescale 1ns/100ps

module tb;
    import lpl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd;
    lpl_mode_e mode_a = LPL_MODE_OFF;
    lpl_mode_e mode_b = LPL_MODE_OFF;
    lpl_sel_t sel_a = 3'h0;
    lpl_sel_t sel_b = 3'h0;
    logic [3:0] val, drv;
    logic [7:0] tbl [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int n_mismatch = 0;
    int n_compared = 0;

    // Clock of 50 ns period.
    always #25 clk = ~clk;

    lpl_top u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .BANK_A_LOW_LOGIC_MODE_I(mode_a),
        .BANK_B_LOW_LOGIC_MODE_I(mode_b), .IO_A_LOW_SEL_I(sel_a), .IO_B_LOW_SEL_I(sel_b),
        .LUT_VALUE_O(val), .LUT_DRIVE_O(drv));

    lpl_host_model u_host (.clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_rdata_i(rdata));

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk4(input logic [3:0] g, input logic [3:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Expected pin drive from the mode fields, the select codes and the shadow tables.
    task automatic chk_pins();
        logic a2, a3, b3;
        a2 = (mode_a == LPL_MODE_3TO1);
        a3 = (mode_a == LPL_MODE_3TO2);
        b3 = (mode_b == LPL_MODE_3TO2);
        chk4(drv, {b3, b3, a3, a2 | a3});
        chk4(val, {b3 & tbl[3][sel_b], b3 & tbl[1][sel_b], a3 & tbl[4][sel_a],
            (a2 & tbl[0][sel_a]) | (a3 & tbl[2][sel_a])});
    endtask

    // Every mode on both banks against every select code, one cycle after each change.
    task automatic sweep();
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 8; s++)
            begin
                @(negedge clk);
                mode_a = lpl_mode_e'(m);
                mode_b = lpl_mode_e'(3 - m);
                sel_a = s[2:0];
                sel_b = ~s[2:0];
                @(negedge clk);
                chk_pins();
            end
    endtask

    task automatic end_of_test();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles.
    initial
    begin
        #500000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            u_host.rd(8'h27 + i[7:0], got);
            chk8(got, 8'h00);
        end
        sweep();
        tbl = '{8'h96, 8'h3C, 8'hA5, 8'h5A, 8'hC3};
        for (int i = 0; i < 5; i++)
            u_host.wr(8'h27 + i[7:0], tbl[i]);
        for (int i = 0; i < 5; i++)
        begin
            u_host.rd(8'h27 + i[7:0], got);
            chk8(got, tbl[i]);
        end
        // Unmapped places ignore writes and read as zero.
        u_host.wr(8'h2C, 8'hFF);
        u_host.rd(8'h2C, got);
        chk8(got, 8'h00);
        u_host.rd(8'h26, got);
        chk8(got, 8'h00);
        sweep();
        // Live table edits: the single-output table must not reach the pins in dual mode.
        @(negedge clk);
        mode_a = LPL_MODE_3TO2;
        sel_a = 3'h5;
        tbl[0] = 8'h00;
        u_host.wr(8'h27, 8'h00);
        @(negedge clk);
        chk_pins();
        tbl[2] = 8'hDF;
        u_host.wr(8'h29, 8'hDF);
        @(negedge clk);
        chk_pins();
        // A write to the dual table with code 0 standing must reach pin 3 one clock later.
        sel_a = 3'h0;
        tbl[2] = 8'h20;
        u_host.wr(8'h29, 8'h20);
        @(negedge clk);
        chk_pins();
        @(negedge clk);
        // A reset in mid-run clears every table loaded above.
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        tbl = '{default: 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            u_host.rd(8'h27 + i[7:0], got);
            chk8(got, 8'h00);
        end
        chk_pins();
        repeat (2) @(negedge clk);
        end_of_test();
    end
endmodule
